// File: hdl/xlate_pkg.sv
// Shared constants and types for two-coordinate address translation
package xlate_pkg;
   localparam int          WORD_W       = 36;
   localparam int          SEG_W        = 18;
   localparam int          NUM_BASE     = 8;
   // Word bit n (0 = most significant) sits at vector index 35-n
   localparam int          I_BASE_HI    = 35;
   localparam int          I_BASE_LO    = 33;
   localparam int          I_Y_HI       = 32;
   localparam int          I_Y_LO       = 18;
   localparam int          I_BASE_MODE  = 6;
   localparam int          W_HALF_LO    = 18;
   localparam int          W_MOD_HI     = 5;
   localparam int          W_MOD_LO     = 0;
   // Pair-indirect modifier codes in the even word
   localparam logic [5:0]  MOD_SEG_PAIR  = 6'h26;
   localparam logic [5:0]  MOD_BASE_PAIR = 6'h27;
   // Descriptor word: origin [35:18], bound [17:2], control [1:0]
   localparam int          D_BND_HI     = 17;
   localparam int          D_BND_LO     = 2;
   localparam logic [1:0]  CTL_UNPAGED  = 2'h0;
   localparam logic [1:0]  CTL_PG1024   = 2'h2;
   localparam logic [1:0]  CTL_PG64     = 2'h3;
   localparam int          WN_1024      = 10;
   localparam int          WN_64        = 6;
   // Base register fields
   localparam int          B_INT        = 18;
   localparam int          B_SEC_HI     = 21;
   localparam int          B_SEC_LO     = 19;
   localparam int          BASE_W       = 22;
   // Register byte offsets
   localparam logic [7:0]  OFS_BASE0    = 8'h00;
   localparam logic [7:0]  OFS_CODE_SEG = 8'h20;
   localparam logic [7:0]  OFS_DT_ORG   = 8'h24;
   localparam logic [7:0]  OFS_DT_SIZE  = 8'h28;
   localparam logic [7:0]  OFS_STATUS   = 8'h2C;
   localparam logic [7:0]  OFS_LAST_ABS = 8'h30;
   localparam int          ST_FAULT     = 0;
   localparam int          ST_BUSY      = 1;

   typedef enum logic [1:0] {
      K_FETCH = 2'h0,
      K_INSTR = 2'h1,
      K_PAIR  = 2'h2,
      K_XFER  = 2'h3
   } kind_t;

   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_SDW  = 2'b01,
      S_PDW  = 2'b11
   } xstate_t;

   typedef struct packed {
      logic [WORD_W-1:0] word0;
      logic [WORD_W-1:0] word1;
      logic [SEG_W-1:0]  index;
      logic              even;
      kind_t             kind;
   } xreq_t;
endpackage : xlate_pkg

// File: hdl/seg_page_xlate.sv
// Segment and page address translation with AHB-Lite register slave
// Contract
// R01 - Eight base registers each hold a segment number.
// R02 - Instruction bit 29 set: top three address bits pick a base register.
// R03 - Base addressing takes segment address from instruction bits 3 to 17.
// R04 - Instruction fetch uses instruction counter with code segment register.
// R05 - Intersegment transfer loads code segment register with the target segment.
// R06 - Pair handling only for even address and pair modifier code.
// R07 - Segment pair: even word bits 0-17 give segment number.
// R08 - Segment pair: odd word bits 0-17 address, bits 30-35 modifier.
// R09 - Base pair: even word bits 0-2 pick base register for segment.
// R10 - Base pair: odd word bits 0-17 address, bits 30-35 modifier.
// R11 - Internal base register contents are added to the instruction address.
// R12 - Internal base register names a second base giving segment number.
// R13 - Core blocks of 64 or 1024 words, aligned to their size.
// R14 - Two descriptor control bits select unpaged, 64 or 1024 pages.
// R15 - Unpaged segment occupies contiguous core from descriptor origin.
// R16 - Paged descriptor address is page table origin; one page size.
// R17 - Page entry holds control field and page block origin.
// R18 - Word number is 10 bits for 1024 pages, 6 for 64.
// R19 - Page number plus table origin fetches entry; word adds to origin.
// R20 - Descriptor table base gives origin and size; segment number indexes it.
// R21 - Unpaged absolute address is descriptor origin plus segment address.
// R22 - Every segment address is checked against the descriptor size.
// R23 - Out-of-range address faults and issues no core reference.
// R24 - Descriptor and page entry reads complete before the next step.
`timescale 1ns/1ns
module seg_page_xlate
   import xlate_pkg::*;
(
   input  wire logic              REF_CLK,
   input  wire logic              RST_N,
   input  wire logic              HSEL,
   input  wire logic [31:0]       HADDR,
   input  wire logic [1:0]        HTRANS,
   input  wire logic              HWRITE,
   input  wire logic [2:0]        HSIZE,
   input  wire logic [31:0]       HWDATA,
   input  wire logic              HREADY,
   output logic      [31:0]       HRDATA,
   output logic                   HREADYOUT,
   output logic                   HRESP,
   input  wire logic              REQ_VALID,
   input  wire xreq_t             REQ,
   input  wire logic [SEG_W-1:0]  INSTR_COUNTER,
   output logic                   REQ_READY,
   output logic                   XLATE_DONE,
   output logic                   XLATE_FAULT,
   output logic      [SEG_W-1:0]  ABS_ADDR,
   output logic                   MEM_REQ,
   output logic      [SEG_W-1:0]  MEM_ADDR,
   input  wire logic              MEM_ACK,
   input  wire logic [WORD_W-1:0] MEM_RDATA
);

   typedef struct packed {
      xstate_t                          state;
      logic [NUM_BASE-1:0][BASE_W-1:0]  base;
      logic [SEG_W-1:0]                 code_seg;
      logic [SEG_W-1:0]                 dt_org;
      logic [SEG_W-1:0]                 dt_size;
      logic [SEG_W-1:0]                 seg_num;
      logic [SEG_W-1:0]                 seg_addr;
      logic [1:0]                       ctl;
      logic                             xfer;
      logic                             mem_req;
      logic [SEG_W-1:0]                 mem_addr;
      logic [SEG_W-1:0]                 abs_addr;
      logic                             ready;
      logic                             done;
      logic                             fault;
      logic                             fault_st;
      logic [31:0]                      hrdata;
      logic                             wr_pend;
      logic [7:0]                       wr_ofs;
   } st_t;

   st_t st_r;
   st_t st_nxt;

   // Segment number a base register supplies; an internal one defers to its second
   function automatic logic [SEG_W-1:0] base_seg(
      input logic [NUM_BASE-1:0][BASE_W-1:0] b,
      input logic [2:0]                      idx);
      logic [BASE_W-1:0] r;
      r = b[idx];
      if (r[B_INT]) begin
         base_seg = b[r[B_SEC_HI:B_SEC_LO]][SEG_W-1:0];
      end else begin
         base_seg = r[SEG_W-1:0];
      end
   endfunction : base_seg

   function automatic logic [31:0] reg_read(input st_t s, input logic [7:0] ofs);
      reg_read = 32'h0000_0000;
      if (ofs < OFS_CODE_SEG && ofs[1:0] == 2'h0) begin
         reg_read = {10'h000, s.base[ofs[4:2]]};
      end else begin
         unique case (ofs)
            OFS_CODE_SEG: reg_read = {14'h0000, s.code_seg};
            OFS_DT_ORG:   reg_read = {14'h0000, s.dt_org};
            OFS_DT_SIZE:  reg_read = {14'h0000, s.dt_size};
            OFS_STATUS:   reg_read = {30'h0000_0000, s.state != S_IDLE, s.fault_st};
            OFS_LAST_ABS: reg_read = {14'h0000, s.abs_addr};
            default:      reg_read = 32'h0000_0000;
         endcase
      end
   endfunction : reg_read

   logic             accept;
   logic [SEG_W-1:0] r_seg;
   logic [SEG_W-1:0] r_addr;
   logic [5:0]       even_mod;
   logic [SEG_W-1:0] odd_addr;
   logic [SEG_W-1:0] y_ext;
   logic [BASE_W-1:0] sel_base;
   logic [SEG_W-1:0] sdw_org;
   logic [15:0]      sdw_bnd;
   logic [SEG_W-1:0] wn_mask;
   logic [SEG_W-1:0] page_num;

   assign accept   = st_r.ready && REQ_VALID;
   assign even_mod = REQ.word0[W_MOD_HI:W_MOD_LO];
   assign y_ext    = {3'h0, REQ.word0[I_Y_HI:I_Y_LO]};
   assign sel_base = st_r.base[REQ.word0[I_BASE_HI:I_BASE_LO]];
   assign sdw_org  = MEM_RDATA[WORD_W-1:W_HALF_LO];
   assign sdw_bnd  = MEM_RDATA[D_BND_HI:D_BND_LO];
   // R18 word-number width
   assign wn_mask  = (st_r.ctl == CTL_PG64) ? 18'h0003F : 18'h003FF;
   // R18 page number taken with the page size of the descriptor being read
   assign page_num = (MEM_RDATA[1:0] == CTL_PG64) ? (st_r.seg_addr >> WN_64)
                                                   : (st_r.seg_addr >> WN_1024);
   // R08 R10 modifier applies the processor's index to the odd word address
   assign odd_addr = REQ.word1[WORD_W-1:W_HALF_LO]
                   + ((REQ.word1[W_MOD_HI:W_MOD_LO] != 6'h00) ? REQ.index : 18'h00000);

   // Two-coordinate address from the request
   always_comb begin
      r_seg  = st_r.code_seg;
      r_addr = REQ.word0[WORD_W-1:W_HALF_LO];
      unique case (REQ.kind)
         // R04 fetch from code segment
         K_FETCH: begin
            r_addr = INSTR_COUNTER;
         end
         K_INSTR, K_XFER: begin
            // R02 base register addressing
            if (REQ.word0[I_BASE_MODE]) begin
               // R01 R12 segment number from base or its partner
               r_seg = base_seg(st_r.base, REQ.word0[I_BASE_HI:I_BASE_LO]);
               // R11 internal base adds a displacement; R03 y field
               if (sel_base[B_INT]) begin
                  r_addr = sel_base[SEG_W-1:0] + y_ext;
               end else begin
                  r_addr = y_ext;
               end
            end
         end
         K_PAIR: begin
            // R06 pair handling only on even word with a pair code
            if (REQ.even && even_mod == MOD_SEG_PAIR) begin
               // R07 segment number from the even word
               r_seg  = REQ.word0[WORD_W-1:W_HALF_LO];
               r_addr = odd_addr;
            end else if (REQ.even && even_mod == MOD_BASE_PAIR) begin
               // R09 base register named by even word bits 0-2
               r_seg  = base_seg(st_r.base, REQ.word0[I_BASE_HI:I_BASE_LO]);
               r_addr = odd_addr;
            end
         end
      endcase
   end

   always_comb begin
      st_nxt      = st_r;
      st_nxt.done  = 1'b0;
      st_nxt.fault = 1'b0;
      // Bus slave: zero wait states, always OKAY
      if (st_r.wr_pend) begin
         if (st_r.wr_ofs < OFS_CODE_SEG) begin
            st_nxt.base[st_r.wr_ofs[4:2]] = HWDATA[BASE_W-1:0];
         end else begin
            unique case (st_r.wr_ofs)
               OFS_CODE_SEG: st_nxt.code_seg = HWDATA[SEG_W-1:0];
               OFS_DT_ORG:   st_nxt.dt_org   = HWDATA[SEG_W-1:0];
               OFS_DT_SIZE:  st_nxt.dt_size  = HWDATA[SEG_W-1:0];
               OFS_STATUS: begin
                  if (HWDATA[ST_FAULT]) begin
                     st_nxt.fault_st = 1'b0;
                  end
               end
               default: ;
            endcase
         end
      end
      st_nxt.wr_pend = 1'b0;
      if (HSEL && HTRANS[1] && HREADY) begin
         st_nxt.wr_pend = HWRITE && (HADDR[31:8] == 24'h000000) && (HADDR[1:0] == 2'h0);
         st_nxt.wr_ofs  = HADDR[7:0];
         st_nxt.hrdata  = (HADDR[31:8] == 24'h000000) ? reg_read(st_r, HADDR[7:0])
                                                       : 32'h0000_0000;
      end
      unique case (st_r.state)
         S_IDLE: begin
            if (accept) begin
               st_nxt.seg_num  = r_seg;
               st_nxt.seg_addr = r_addr;
               st_nxt.xfer     = (REQ.kind == K_XFER);
               // R20 descriptor index checked against table size
               if (r_seg > st_r.dt_size) begin
                  st_nxt.fault = 1'b1;
               end else begin
                  st_nxt.state    = S_SDW;
                  st_nxt.mem_req  = 1'b1;
                  st_nxt.mem_addr = st_r.dt_org + r_seg;
               end
            end
         end
         S_SDW: begin
            // R24 wait for the descriptor read to finish
            if (MEM_ACK) begin
               st_nxt.mem_req = 1'b0;
               st_nxt.ctl     = MEM_RDATA[1:0];
               // R22 R23 bound check before any operand reference
               if (st_r.seg_addr[D_BND_HI:D_BND_LO] > sdw_bnd) begin
                  st_nxt.fault = 1'b1;
                  st_nxt.state = S_IDLE;
               end else if (MEM_RDATA[1]) begin
                  // R14 R16 paged: origin field locates the page table
                  st_nxt.state    = S_PDW;
                  st_nxt.mem_req  = 1'b1;
                  st_nxt.mem_addr = sdw_org + page_num;
               end else begin
                  // R15 R21 unpaged contiguous segment
                  st_nxt.abs_addr = sdw_org + st_r.seg_addr;
                  st_nxt.done     = 1'b1;
                  st_nxt.state    = S_IDLE;
               end
            end
         end
         S_PDW: begin
            if (MEM_ACK) begin
               st_nxt.mem_req  = 1'b0;
               // R13 R17 R19 aligned page origin plus word number
               st_nxt.abs_addr = (sdw_org & ~wn_mask) + (st_r.seg_addr & wn_mask);
               st_nxt.done     = 1'b1;
               st_nxt.state    = S_IDLE;
            end
         end
         default: st_nxt.state = S_IDLE;
      endcase
      // R05 transfer loads the code segment; wins over a bus write
      if (st_nxt.done && st_r.xfer) begin
         st_nxt.code_seg = st_r.seg_num;
      end
      // Fault flag: a new fault wins over a clear
      if (st_nxt.fault) begin
         st_nxt.fault_st = 1'b1;
      end
      st_nxt.ready = (st_nxt.state == S_IDLE);
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         st_r       <= '0;
         st_r.ready <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign HRDATA      = st_r.hrdata;
   assign HREADYOUT   = 1'b1;
   assign HRESP       = 1'b0;
   assign REQ_READY   = st_r.ready;
   assign XLATE_DONE  = st_r.done;
   assign XLATE_FAULT = st_r.fault;
   assign ABS_ADDR    = st_r.abs_addr;
   assign MEM_REQ     = st_r.mem_req;
   assign MEM_ADDR    = st_r.mem_addr;

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);

   property p_mem_hold;
      MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR);
   endproperty
   a_mem_hold: assert property (p_mem_hold) else $error("core read dropped early"); // R24

   property p_sdw_addr;
      (st_r.state == S_SDW) |-> (MEM_ADDR == st_r.dt_org + st_r.seg_num);
   endproperty
   a_sdw_addr: assert property (p_sdw_addr) else $error("descriptor address wrong"); // R20

   property p_fault_quiet;
      XLATE_FAULT |-> !MEM_REQ && !XLATE_DONE;
   endproperty
   a_fault_quiet: assert property (p_fault_quiet) else $error("fault with core reference"); // R23

   property p_fetch_seg;
      accept && REQ.kind == K_FETCH |=> st_r.seg_addr == $past(INSTR_COUNTER)
                                         && st_r.seg_num == $past(st_r.code_seg);
   endproperty
   a_fetch_seg: assert property (p_fetch_seg) else $error("fetch coordinates wrong"); // R04

   property p_base_plain;
      accept && REQ.kind == K_INSTR && REQ.word0[I_BASE_MODE] && !sel_base[B_INT]
         |=> st_r.seg_num == $past(sel_base[SEG_W-1:0])
             && st_r.seg_addr == $past(y_ext);
   endproperty
   a_base_plain: assert property (p_base_plain) else $error("base addressing wrong"); // R02

   property p_seg_pair;
      accept && REQ.kind == K_PAIR && REQ.even && even_mod == MOD_SEG_PAIR
         |=> st_r.seg_num == $past(REQ.word0[WORD_W-1:W_HALF_LO]);
   endproperty
   a_seg_pair: assert property (p_seg_pair) else $error("segment pair number wrong"); // R07

   property p_bound;
      (st_r.state == S_SDW) && MEM_ACK && (st_r.seg_addr[D_BND_HI:D_BND_LO] > sdw_bnd)
         |=> XLATE_FAULT ##1 !MEM_REQ;
   endproperty
   a_bound: assert property (p_bound) else $error("bound violation missed"); // R22

   property p_unpaged;
      (st_r.state == S_SDW) && MEM_ACK && !MEM_RDATA[1]
         && !(st_r.seg_addr[D_BND_HI:D_BND_LO] > sdw_bnd)
         |=> XLATE_DONE && ABS_ADDR == $past(sdw_org + st_r.seg_addr);
   endproperty
   a_unpaged: assert property (p_unpaged) else $error("unpaged address wrong"); // R21

   property p_paged;
      (st_r.state == S_PDW) && MEM_ACK |=> XLATE_DONE && REQ_READY && !MEM_REQ;
   endproperty
   a_paged: assert property (p_paged) else $error("paged completion wrong"); // R19

   property p_xfer;
      XLATE_DONE && $past(st_r.xfer) |-> st_r.code_seg == $past(st_r.seg_num);
   endproperty
   a_xfer: assert property (p_xfer) else $error("code segment not loaded"); // R05

   c_paged:   cover property ((st_r.state == S_PDW) && MEM_ACK);
   c_fault:   cover property (XLATE_FAULT);
   c_xfer:    cover property (XLATE_DONE && st_r.xfer);
   c_busread: cover property (HSEL && HTRANS[1] && !HWRITE ##1 HRDATA != 32'h0);
endmodule : seg_page_xlate

// File: test/core_mem_model.sv
// Core memory model that answers descriptor and page entry reads
`timescale 1ns/1ns
module core_mem_model
   import xlate_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic [2:0]        delay,
   input  wire logic              mem_req,
   input  wire logic [SEG_W-1:0]  mem_addr,
   output logic                   mem_ack,
   output logic      [WORD_W-1:0] mem_rdata,
   output logic                   addr_err
);
   logic [WORD_W-1:0] mem [logic [SEG_W-1:0]];
   logic [WORD_W-1:0] last_q;
   logic [SEG_W-1:0]  held_q;
   logic [2:0]        cnt_q;
   logic              wait_q;

   task automatic put(input logic [SEG_W-1:0] a, input logic [WORD_W-1:0] d);
      mem[a] = d;
   endtask : put

   // Delay zero answers in the first request cycle
   assign mem_ack = mem_req && (cnt_q == delay);

   // Idle data is the inverse of the last word, never a stale copy
   always @* begin
      if (mem_ack) begin
         mem_rdata = mem.exists(mem_addr) ? mem[mem_addr] : '0;
      end else begin
         mem_rdata = ~last_q;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         cnt_q    <= 3'h0;
         wait_q   <= 1'b0;
         last_q   <= '0;
         addr_err <= 1'b0;
      end else begin
         cnt_q <= (mem_req && !mem_ack) ? cnt_q + 3'h1 : 3'h0;
         if (wait_q && (!mem_req || mem_addr !== held_q)) begin
            addr_err <= 1'b1;
         end
         wait_q <= mem_req && !mem_ack;
         held_q <= mem_addr;
         if (mem_ack) begin
            last_q <= mem_rdata;
         end
      end
   end
endmodule : core_mem_model

// File: test/tb_top.sv
// Self-checking bench for segment and page translation
`timescale 1ns/1ns
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin miscompares++; \
   $display("MISMATCH %0t %s", $time, m); end end
module tb_top;
   import xlate_pkg::*;
   localparam int         RW = $bits(xreq_t);
   logic                  REF_CLK, RST_N, HSEL, HWRITE, HREADYOUT, HRESP;
   logic [31:0]           HADDR, HWDATA, HRDATA;
   logic [1:0]            HTRANS;
   logic [2:0]            HSIZE, MEM_DELAY;
   logic                  REQ_VALID, REQ_READY, XLATE_DONE, XLATE_FAULT;
   logic                  MEM_REQ, MEM_ACK, ADDR_ERR;
   xreq_t                 REQ;
   logic [SEG_W-1:0]      INSTR_COUNTER, ABS_ADDR, MEM_ADDR;
   logic [WORD_W-1:0]     MEM_RDATA;
   logic [BASE_W-1:0]     bases [NUM_BASE];
   logic [SEG_W-1:0]      code_seg, dt_org, dt_size, last_abs, got [$];
   logic [31:0]           seed, rd_v;
   xreq_t                 req_v;
   int                    miscompares, checked, cycles;

   seg_page_xlate DUT (.REF_CLK(REF_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .REQ_VALID(REQ_VALID),
      .REQ(REQ), .INSTR_COUNTER(INSTR_COUNTER), .REQ_READY(REQ_READY),
      .XLATE_DONE(XLATE_DONE), .XLATE_FAULT(XLATE_FAULT), .ABS_ADDR(ABS_ADDR),
      .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA));
   core_mem_model u_mem (.clk(REF_CLK), .rst_n(RST_N), .delay(MEM_DELAY), .mem_req(MEM_REQ),
      .mem_addr(MEM_ADDR), .mem_ack(MEM_ACK), .mem_rdata(MEM_RDATA), .addr_err(ADDR_ERR));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic finish_test();
      if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test

   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge REF_CLK);
      HSEL   <= 1'b1;
      HTRANS <= 2'h2;
      HADDR  <= a;
      HWRITE <= wr;
      HSIZE  <= 3'h2;
      do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
      HTRANS <= 2'h0;
      HSEL   <= 1'b0;
      HWDATA <= wd;
      do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
      rd = HRDATA;
   endtask : ahb

   // Segment number and address as the processor forms them
   function automatic void locate(input xreq_t r, input logic [SEG_W-1:0] ic,
                                  output logic [SEG_W-1:0] sn, output logic [SEG_W-1:0] sa);
      logic [BASE_W-1:0] b;
      logic [SEG_W-1:0]  bs;
      b  = bases[r.word0[I_BASE_HI:I_BASE_LO]];
      // An internal base defers its segment number to its partner
      bs = b[B_INT] ? bases[b[B_SEC_HI:B_SEC_LO]][SEG_W-1:0] : b[SEG_W-1:0];
      sn = code_seg;
      sa = r.word0[35:18];
      if (r.kind == K_FETCH) sa = ic;
      if ((r.kind == K_INSTR || r.kind == K_XFER) && r.word0[I_BASE_MODE]) begin
         sn = bs;
         sa = {3'h0, r.word0[I_Y_HI:I_Y_LO]};
         if (b[B_INT]) sa = b[SEG_W-1:0] + sa;
      end
      if (r.kind == K_PAIR && r.even &&
          (r.word0[5:0] == MOD_SEG_PAIR || r.word0[5:0] == MOD_BASE_PAIR)) begin
         sa = r.word1[35:18] + ((r.word1[5:0] != 6'h0) ? r.index : 18'h0);
         sn = (r.word0[5:0] == MOD_SEG_PAIR) ? r.word0[35:18] : bs;
      end
   endfunction : locate

   task automatic run_one(input xreq_t r, input logic [SEG_W-1:0] ic);
      logic [SEG_W-1:0]  sn, sa, a1, a2, pg, mk, ea;
      logic [SEG_W-1:0]  ex [$];
      logic [WORD_W-1:0] segment_descriptor_word, page_entry_word;
      logic              ef, done, flt;
      logic [31:0]       rd;
      locate(r, ic, sn, sa);
      a1  = dt_org + sn;
      segment_descriptor_word = WORD_W'({rnd(), rnd()});
      page_entry_word = WORD_W'({rnd(), rnd()});
      segment_descriptor_word[D_BND_HI:D_BND_LO] = (rnd() % 4 == 0) ? sa[17:2] - 16'h1 :
                               (rnd() % 2 == 0) ? sa[17:2] : 16'hFFFF;
      mk = segment_descriptor_word[0] ? 18'h3F : 18'h3FF;
      pg = segment_descriptor_word[0] ? sa >> WN_64 : sa >> WN_1024;
      a2 = segment_descriptor_word[35:18] + pg;
      if (a2 == a1) segment_descriptor_word[1] = 1'b0;
      u_mem.put(a1, segment_descriptor_word);
      if (segment_descriptor_word[1]) u_mem.put(a2, page_entry_word);
      ef = sn > dt_size;
      if (!ef) ex.push_back(a1);
      if (!ef) ef = sa[17:2] > segment_descriptor_word[D_BND_HI:D_BND_LO];
      if (!ef && segment_descriptor_word[1]) ex.push_back(a2);
      ea = segment_descriptor_word[1] ? (page_entry_word[35:18] & ~mk) + (sa & mk) : segment_descriptor_word[35:18] + sa;
      @(posedge REF_CLK);
      MEM_DELAY     <= 3'(rnd() % 4);
      REQ           <= r;
      INSTR_COUNTER <= ic;
      REQ_VALID     <= 1'b1;
      do @(posedge REF_CLK); while (REQ_READY !== 1'b1);
      REQ_VALID <= 1'b0;
      got.delete();
      done = 1'b0;
      flt  = 1'b0;
      for (int n = 0; n < 40 && !(done || flt); n++) begin
         @(posedge REF_CLK);
         if (MEM_ACK === 1'b1) got.push_back(MEM_ADDR);
         done = (XLATE_DONE === 1'b1);
         flt  = (XLATE_FAULT === 1'b1);
      end
      `CHK(flt, ef, "fault flag");
      `CHK(done, !ef, "done flag");
      if (!ef) `CHK(ABS_ADDR, ea, "absolute address");
      `CHK(got.size(), ex.size(), "core read count");
      foreach (ex[i]) `CHK(got[i], ex[i], "core read address");
      if (!ef) last_abs = ea;
      if (!ef && r.kind == K_XFER) code_seg = sn;
      ahb(1'b0, OFS_STATUS, 32'h0, rd);
      `CHK(rd[1:0], {1'b0, ef}, "status");
      if (ef) ahb(1'b1, OFS_STATUS, 32'h1, rd);
      ahb(1'b0, OFS_LAST_ABS, 32'h0, rd);
      `CHK(rd, {14'h0, last_abs}, "last absolute");
      ahb(1'b0, OFS_CODE_SEG, 32'h0, rd);
      `CHK(rd, {14'h0, code_seg}, "code segment");
   endtask : run_one

   task automatic program_regs();
      logic [31:0] rd;
      // Small segment numbers so that table overflow is hit now and then
      for (int i = 0; i < NUM_BASE; i++) begin
         bases[i] = BASE_W'(rnd()) & 22'h3C003F;
         ahb(1'b1, OFS_BASE0 + 4 * i, 32'(bases[i]), rd);
      end
      code_seg = 18'(rnd()) & 18'h3F;
      dt_org   = 18'(rnd());
      dt_size  = 18'h30;
      ahb(1'b1, OFS_CODE_SEG, 32'(code_seg), rd);
      ahb(1'b1, OFS_DT_ORG, 32'(dt_org), rd);
      ahb(1'b1, OFS_DT_SIZE, 32'(dt_size), rd);
      ahb(1'b1, OFS_LAST_ABS, 32'h15, rd);
      for (int i = 0; i < NUM_BASE; i++) begin
         ahb(1'b0, OFS_BASE0 + 4 * i, 32'h0, rd);
         `CHK(rd, 32'(bases[i]), "base register");
      end
      ahb(1'b0, OFS_LAST_ABS, 32'h0, rd);
      `CHK(rd, {14'h0, last_abs}, "read-only register");
   endtask : program_regs

   initial begin
      REF_CLK = 1'b0;
      forever #10 REF_CLK = ~REF_CLK;
   end

   always @(posedge REF_CLK) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         $display("MISMATCH %0t timeout", $time);
         finish_test();
      end
   end

   initial begin
      seed          = 32'h2A06;
      RST_N         = 1'b0;
      HSEL          = 1'b0;
      HADDR         = 32'h0;
      HTRANS        = 2'h0;
      HWRITE        = 1'b0;
      HSIZE         = 3'h0;
      HWDATA        = 32'h0;
      REQ_VALID     = 1'b0;
      REQ           = '0;
      INSTR_COUNTER = 18'h0;
      MEM_DELAY     = 3'h0;
      last_abs      = 18'h0;
      repeat (12) @(posedge REF_CLK);
      RST_N <= 1'b1;
      // Every register plus one unmapped place read zero
      for (int i = 0; i < 14; i++) begin
         ahb(1'b0, (i == 13) ? 32'h100 : 4 * i, 32'h0, rd_v);
         `CHK(rd_v, 32'h0, "reset or unmapped value");
         `CHK(HRESP, 1'b0, "bus response");
      end
      program_regs();
      for (int k = 0; k < 300; k++) begin
         req_v = RW'({rnd(), rnd(), rnd(), rnd()});
         // Mostly base addressing, plain code-segment operands now and then
         if (req_v.kind != K_PAIR && req_v.index[2]) req_v.word0[I_BASE_MODE] = 1'b1;
         if (req_v.kind == K_PAIR && req_v.even)
            req_v.word0[5:0] = req_v.index[0] ? MOD_SEG_PAIR : MOD_BASE_PAIR;
         if (req_v.word0[5:0] == MOD_SEG_PAIR) req_v.word0[35:24] = 12'h0;
         if (req_v.index[1]) req_v.word1[5:0] = 6'h0;
         if (k % 75 == 74) program_regs();
         run_one(req_v, 18'(rnd()));
      end
      @(posedge REF_CLK);
      RST_N <= 1'b0;
      repeat (3) @(posedge REF_CLK);
      RST_N <= 1'b1;
      ahb(1'b0, OFS_CODE_SEG, 32'h0, rd_v);
      `CHK(rd_v, 32'h0, "code segment after reset");
      `CHK(ADDR_ERR, 1'b0, "core read protocol");
      finish_test();
   end
endmodule : tb_top
